/* hw/sfg_defines.svh */
`ifndef SFG_DEFINES_SVH
`define SFG_DEFINES_SVH

// Register byte offsets
`define SFG_OFS_CLEAR 8'h00
`define SFG_OFS_ACT_FAULT 8'h04
`define SFG_OFS_ACT_WARN 8'h08
`define SFG_OFS_STATUS 8'h0C
`define SFG_OFS_DI_FUNC 8'h10
`define SFG_OFS_HIST_FIRST 8'h40
`define SFG_OFS_HIST_LAST 8'h64

// Field values and sizes
`define SFG_CLEAR_RST 1'h0
`define SFG_DI_FN_CLEAR 4'h2
`define SFG_NUM_DI 4
`define SFG_HIST_DEPTH 5
`define SFG_CODE_W 8
`define SFG_STAT_W 16
`define SFG_CAT1 2'h0
`define SFG_CAT4 2'h3
`endif

/* hw/sfg_pkg.sv */
`include "sfg_defines.svh"

package sfg_pkg;

    typedef enum logic [1:0] {
        ST_READY,
        ST_RUN,
        ST_FAULT
    } sfg_state_e;

    typedef logic [`SFG_CODE_W-1:0] sfg_code_t;

    // Event from detection logic; cat is category minus one
    typedef struct packed {
        logic valid;
        logic [1:0] cat;
        sfg_code_t code;
        logic [`SFG_STAT_W-1:0] status;
    } sfg_event_s;

    // One history entry: status snapshot and code
    typedef struct packed {
        logic [`SFG_STAT_W-1:0] status;
        sfg_code_t code;
    } sfg_entry_s;

    typedef struct packed {
        logic [`SFG_HIST_DEPTH-1:0][`SFG_STAT_W+`SFG_CODE_W-1:0] ent;
    } sfg_hist_s;

    typedef struct packed {
        logic srv_s1;
        logic srv_s2;
        logic srv_q;
        logic [`SFG_NUM_DI-1:0] di_s1;
        logic [`SFG_NUM_DI-1:0] di_s2;
        logic clr_param;
        logic [`SFG_NUM_DI*4-1:0] di_func;
        logic flt_act;
        logic [1:0] flt_cat;
        sfg_code_t flt_code;
        logic wrn_act;
        sfg_code_t wrn_code;
        sfg_state_e state;
        logic set_pend;
        logic apply;
        logic ap_wr;
        logic [7:0] ap_addr;
        logic [31:0] hrdata;
    } sfg_top_s;

endpackage : sfg_pkg

/* hw/sfg_history.sv */
`include "sfg_defines.svh"

module sfg_history (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // New entry
    input wire logic push_i,
    input sfg_pkg::sfg_entry_s entry_i,
    // Stored entries, newest first
    output sfg_pkg::sfg_hist_s hist_o
);
    import sfg_pkg::*;

    sfg_hist_s r;
    sfg_hist_s next_r;

    ////////////////////////////////////////////////////////////////////////
    // Shift register of entries
    always_comb begin
        next_r = r;
        if (push_i) begin
            next_r.ent[0] = entry_i;
            for (int i = 1; i < `SFG_HIST_DEPTH; i++) begin
                next_r.ent[i] = r.ent[i-1];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign hist_o = r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_hist_capture: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        push_i |=> (r.ent[0] == $past(entry_i)) &&
            (r.ent[1] == $past(r.ent[0])))
        else $error("history entry not captured");

    chk_hist_kept: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        !push_i |=> $stable(r))
        else $error("history changed without new entry");

endmodule : sfg_history

/* hw/sfg_top.sv */
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`include "sfg_defines.svh"

module sfg_top (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Pins
    input wire logic servo_enable_i,
    input wire logic [`SFG_NUM_DI-1:0] digital_in_i,
    // Detection logic
    input sfg_pkg::sfg_event_s event_i,
    input wire logic fault_cause_i,
    input wire logic warning_cause_i,
    input wire logic setting_changed_i,
    // Drive status
    output sfg_pkg::sfg_state_e drive_state_o,
    output logic fault_o,
    output logic warning_o,
    output logic apply_settings_o
);
    import sfg_pkg::*;

    sfg_top_s r;
    sfg_top_s next_r;

    logic [`SFG_NUM_DI-1:0] di_hit;
    logic di_clear;
    logic clear_req;
    logic srv_on;
    logic flt_ok;
    logic wrn_ok;
    logic is_warn;
    logic ap_valid;
    logic wr_clear;
    logic fault_push;
    logic warn_push;
    logic [7:0] hidx;
    logic [31:0] rd_val;
    sfg_entry_s ev_entry;
    sfg_hist_s fault_hist;
    sfg_hist_s warn_hist;

    ////////////////////////////////////////////////////////////////////////
    // Clear sources

    // Per input function decode
    genvar gi;
    generate
        for (gi = 0; gi < `SFG_NUM_DI; gi++) begin : g_di
            assign di_hit[gi] = r.di_s2[gi] &&
                (r.di_func[gi*4 +: 4] == `SFG_DI_FN_CLEAR);
        end
    endgenerate

    assign di_clear = |di_hit;
    assign clear_req = r.clr_param | di_clear;
    assign srv_on = r.srv_s2;

    // Category gating
    assign flt_ok = clear_req && r.flt_act &&
        (r.flt_cat != `SFG_CAT1) &&
        !srv_on &&
        !fault_cause_i;
    assign wrn_ok = clear_req && r.wrn_act && !warning_cause_i;

    // Grading of incoming events
    assign is_warn = (event_i.cat == `SFG_CAT4);
    assign fault_push = event_i.valid && !is_warn;
    assign warn_push = event_i.valid && is_warn;

    assign ev_entry.code = event_i.code;
    assign ev_entry.status = event_i.status;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign ap_valid = hsel_i && htrans_i[1] && hready_i;
    assign wr_clear = r.ap_wr && (r.ap_addr == `SFG_OFS_CLEAR);
    assign hidx = 8'((haddr_i[7:0] - `SFG_OFS_HIST_FIRST) >> 2);

    always_comb begin
        rd_val = 32'h0000_0000;
        case (haddr_i[7:0])
            `SFG_OFS_CLEAR: begin
                rd_val[0] = r.clr_param;
            end
            `SFG_OFS_ACT_FAULT: begin
                rd_val[`SFG_CODE_W-1:0] = r.flt_code;
                rd_val[31] = r.flt_act;
            end
            `SFG_OFS_ACT_WARN: begin
                rd_val[`SFG_CODE_W-1:0] = r.wrn_code;
                rd_val[31] = r.wrn_act;
            end
            `SFG_OFS_STATUS: begin
                rd_val[1:0] = r.state;
                rd_val[3:2] = r.flt_cat;
                rd_val[4] = srv_on;
                rd_val[5] = r.set_pend;
                rd_val[8 +: `SFG_NUM_DI] = r.di_s2;
            end
            `SFG_OFS_DI_FUNC: begin
                rd_val[`SFG_NUM_DI*4-1:0] = r.di_func;
            end
            default: begin
                if (haddr_i[7:0] >= `SFG_OFS_HIST_FIRST &&
                    haddr_i[7:0] <= `SFG_OFS_HIST_LAST &&
                    haddr_i[1:0] == 2'h0) begin
                    if (hidx < 8'(`SFG_HIST_DEPTH)) begin
                        rd_val[23:0] = fault_hist.ent[hidx];
                    end else begin
                        rd_val[23:0] =
                            warn_hist.ent[hidx - 8'(`SFG_HIST_DEPTH)];
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_r = r;

        // Pin synchronisers
        next_r.srv_s1 = servo_enable_i;
        next_r.srv_s2 = r.srv_s1;
        next_r.srv_q = r.srv_s2;
        next_r.di_s1 = digital_in_i;
        next_r.di_s2 = r.di_s1;

        // One clear per write of 1
        if (r.clr_param) begin
            next_r.clr_param = 1'b0;
        end

        // Fault clear and drive state
        if (flt_ok) begin
            next_r.flt_act = 1'b0;
            next_r.state = srv_on ? ST_RUN : ST_READY;
        end else if (r.state != ST_FAULT) begin
            next_r.state = srv_on ? ST_RUN : ST_READY;
        end

        // Warning clear
        if (wrn_ok) begin
            next_r.wrn_act = 1'b0;
        end

        // New events win over clears
        if (fault_push) begin
            if (!r.flt_act || !flt_ok && (event_i.cat <= r.flt_cat) ||
                flt_ok) begin
                next_r.flt_code = event_i.code;
                next_r.flt_cat = event_i.cat;
            end
            next_r.flt_act = 1'b1;
            next_r.state = ST_FAULT;
        end
        if (warn_push) begin
            next_r.wrn_code = event_i.code;
            next_r.wrn_act = 1'b1;
        end

        // Pending settings wait for servo-off, never for a clear
        next_r.apply = 1'b0;
        if (r.set_pend && r.srv_q && !r.srv_s2) begin
            next_r.apply = 1'b1;
            next_r.set_pend = 1'b0;
        end
        if (setting_changed_i) begin
            next_r.set_pend = 1'b1;
        end

        // Address phase capture
        next_r.ap_wr = ap_valid && hwrite_i;
        next_r.ap_addr = haddr_i[7:0];
        if (ap_valid && !hwrite_i) begin
            next_r.hrdata = rd_val;
        end

        // Data phase writes
        if (wr_clear && hwdata_i[31:1] == 31'h0000_0000) begin
            next_r.clr_param = hwdata_i[0];
        end
        if (r.ap_wr && r.ap_addr == `SFG_OFS_DI_FUNC) begin
            next_r.di_func = hwdata_i[`SFG_NUM_DI*4-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // History

    sfg_history u_fault_hist (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .push_i(fault_push),
        .entry_i(ev_entry),
        .hist_o(fault_hist)
    );

    sfg_history u_warn_hist (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .push_i(warn_push),
        .entry_i(ev_entry),
        .hist_o(warn_hist)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hrdata_o = r.hrdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign drive_state_o = r.state;
    assign fault_o = r.flt_act;
    assign warning_o = r.wrn_act;
    assign apply_settings_o = r.apply;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_cat1_latched: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        r.flt_act && r.flt_cat == `SFG_CAT1 |=> r.flt_act &&
            r.state == ST_FAULT)
        else $error("category 1 fault was cleared");

    chk_servo_gate: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        r.flt_act && r.srv_s2 |=> r.flt_act)
        else $error("fault cleared with servo enabled");

    chk_warn_clear: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        r.wrn_act && r.clr_param && !warning_cause_i && !warn_push
        |=> !r.wrn_act)
        else $error("warning not cleared by request");

    chk_cause_hold: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        r.flt_act && fault_cause_i |=> r.flt_act ##1 1'b1)
        else $error("fault cleared while cause present");

    chk_clear_state: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        r.state == ST_FAULT && clear_req && r.flt_act &&
        r.flt_cat != `SFG_CAT1 && !r.srv_s2 && !fault_cause_i &&
        !fault_push |=> r.state == ST_READY && !r.flt_act)
        else $error("no ready state after clear");

    chk_di_clear: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        di_clear && r.wrn_act && !warning_cause_i && !warn_push
        |=> !r.wrn_act)
        else $error("clear input did not clear warning");

    chk_param_once: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        $rose(r.clr_param) && !wr_clear |=> !r.clr_param)
        else $error("clear request did not return to 0");

    chk_apply_edge: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        r.apply |-> $past(r.srv_q) && !$past(r.srv_s2))
        else $error("settings applied without servo-off");

    chk_fault_grade: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        fault_push |=> r.flt_act && r.state == ST_FAULT)
        else $error("fault event not latched");

    chk_warn_grade: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        warn_push |=> r.wrn_act && r.wrn_code == $past(event_i.code))
        else $error("warning event not latched");

    chk_cat_order: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        fault_push && r.flt_act && !flt_ok && event_i.cat > r.flt_cat
        |=> r.flt_cat == $past(r.flt_cat))
        else $error("less severe fault replaced active one");

    chk_param_range: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        wr_clear && hwdata_i[31:1] != 31'h0000_0000 |=> !r.clr_param)
        else $error("out of range clear value accepted");

    chk_param_set: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        wr_clear && hwdata_i == 32'h0000_0001 |=> r.clr_param)
        else $error("clear request not taken");

    chk_warn_cause: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        r.wrn_act && warning_cause_i |=> r.wrn_act)
        else $error("warning cleared while cause present");

    chk_no_request: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        r.flt_act && !clear_req |=> r.flt_act)
        else $error("fault cleared without a request");

    chk_state_follow: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        r.state != ST_FAULT && !fault_push
        |=> r.state == (r.srv_q ? ST_RUN : ST_READY))
        else $error("drive state does not follow servo enable");

    chk_apply_pulse: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        r.apply |=> !r.apply)
        else $error("settings apply longer than one cycle");

    chk_active_read: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        ap_valid && !hwrite_i && haddr_i[7:0] == `SFG_OFS_ACT_FAULT
        |=> hrdata_o == {$past(r.flt_act), 23'h00_0000, $past(r.flt_code)})
        else $error("active fault read wrong");

    chk_hist_read: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        ap_valid && !hwrite_i && haddr_i[7:0] == `SFG_OFS_HIST_LAST
        |=> hrdata_o == {8'h00, $past(warn_hist.ent[`SFG_HIST_DEPTH-1])})
        else $error("oldest warning read wrong");

    chk_param_idle: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        !wr_clear |=> r.clr_param == `SFG_CLEAR_RST)
        else $error("clear request held without a write");

endmodule : sfg_top

/* dv/sfg_host.sv */
module sfg_host (
    // Clock
    input wire logic clk_i,
    // Pins toward the drive
    output logic servo_enable_o,
    output logic [3:0] digital_in_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        servo_enable_o = 1'b0;
        digital_in_o = 4'h0;
    end

    // Servo pin, held until synchronised
    task automatic set_servo(input logic v);
        @(posedge clk_i);
        servo_enable_o <= v;
        repeat (4) @(posedge clk_i);
    endtask : set_servo

    // Valid level on one input, then back to invalid
    task automatic pulse_di(input int i);
        @(posedge clk_i);
        digital_in_o[i] <= 1'b1;
        repeat (5) @(posedge clk_i);
        digital_in_o[i] <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : pulse_di
endmodule : sfg_host

/* dv/sfg_top_tb.sv */
module sfg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sfg_pkg::*;
    logic clk_sys_i = 0;
    logic rst_n_i = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic hwrite = 0, hready, hresp, fault, warning, apply, servo;
    logic f_cause = 0, w_cause = 0, set_chg = 0;
    logic [3:0] di;
    sfg_event_s ev = '0;
    sfg_state_e state;
    int n_fail = 0, checked = 0, cyc = 0, n_apply = 0;
    int m_flt = 0, m_cat = 0, m_fc = 0, m_wrn = 0, m_wc = 0, m_srv = 0;
    int hf[$], hw[$];

    ////////////////////////////////////////////////////////////////////////
    sfg_host u_host (.clk_i(clk_sys_i), .servo_enable_o(servo),
        .digital_in_o(di));
    sfg_top u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .servo_enable_i(servo), .digital_in_i(di),
        .event_i(ev), .fault_cause_i(f_cause),
        .warning_cause_i(w_cause), .setting_changed_i(set_chg),
        .drive_state_o(state), .fault_o(fault), .warning_o(warning),
        .apply_settings_o(apply));

    ////////////////////////////////////////////////////////////////////////
    always #5 clk_sys_i = ~clk_sys_i;

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (apply === 1'b1) n_apply <= n_apply + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Single AHB-Lite transfer
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys_i);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r & m, e & m);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    // Event into the drive and into the model
    task automatic fire(input logic [1:0] cat, input logic cause);
        logic [7:0] c;
        logic [15:0] s;
        c = 8'($urandom);
        s = 16'($urandom);
        @(posedge clk_sys_i);
        ev <= '{1'b1, cat, c, s};
        if (cat == 2'h3) w_cause <= cause;
        else f_cause <= cause;
        @(posedge clk_sys_i);
        ev <= '0;
        if (cat == 2'h3) begin
            m_wrn = 1;
            m_wc = c;
            hw.push_front({s, c});
        end else begin
            if (m_flt == 0 || cat <= m_cat) begin
                m_fc = c;
                m_cat = cat;
            end
            m_flt = 1;
            hf.push_front({s, c});
        end
    endtask : fire

    // Model of a clear request
    task automatic m_clear();
        if (m_flt && m_cat != 0 && !m_srv && !f_cause) m_flt = 0;
        if (m_wrn && !w_cause) m_wrn = 0;
    endtask : m_clear

    task automatic clr_param();
        wr(8'h00, 32'h1);
        repeat (2) @(posedge clk_sys_i);
        m_clear();
        rd(8'h00, '1, 32'h0);
    endtask : clr_param

    task automatic servo_to(input logic v);
        u_host.set_servo(v);
        m_srv = v;
    endtask : servo_to

    task automatic check_all();
        @(negedge clk_sys_i);
        chk(fault, m_flt);
        chk(warning, m_wrn);
        chk(state, m_flt ? 2 : m_srv);
        chk(hresp, 32'h0000_0000);
        rd(8'h04, m_flt ? '1 : 32'h8000_0000,
            {m_flt[0], 23'h00_0000, 8'(m_fc)});
        rd(8'h08, m_wrn ? '1 : 32'h8000_0000,
            {m_wrn[0], 23'h00_0000, 8'(m_wc)});
        rd(8'h0C, 32'h0000_0013,
            {27'h000_0000, m_srv[0], 2'h0, 2'(m_flt ? 2 : m_srv)});
        for (int i = 0; i < 5; i++) begin
            rd(8'h40 + 8'(4 * i), '1, i < hf.size() ? hf[i] : 0);
            rd(8'h54 + 8'(4 * i), '1, i < hw.size() ? hw[i] : 0);
        end
    endtask : check_all

    ////////////////////////////////////////////////////////////////////////
    initial begin
        m_cat = $urandom(38);
        m_cat = 0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(8'h00, '1, 32'h0);
        rd(8'h10, '1, 32'h0);
        rd(8'hF0, '1, 32'h0);
        check_all();
        // Warning cleared with servo on, bad value ignored
        servo_to(1);
        fire(2'h3, 1'b0);
        wr(8'h00, 32'h2);
        repeat (2) @(posedge clk_sys_i);
        check_all();
        w_cause <= 1'b1;
        clr_param();
        check_all();
        w_cause <= 1'b0;
        clr_param();
        check_all();
        // Category 2: servo on, then cause, then clean clear
        fire(2'h1, 1'b1);
        clr_param();
        check_all();
        servo_to(0);
        clr_param();
        check_all();
        f_cause <= 1'b0;
        clr_param();
        check_all();
        // Category 3 by input: wrong function, then function 2
        fire(2'h2, 1'b0);
        @(posedge clk_sys_i);
        set_chg <= 1'b1;
        @(posedge clk_sys_i);
        set_chg <= 1'b0;
        u_host.pulse_di(0);
        check_all();
        wr(8'h10, 32'h20);
        rd(8'h10, '1, 32'h20);
        fire(2'h3, 1'b0);
        u_host.pulse_di(1);
        m_clear();
        check_all();
        chk(n_apply, 0);
        servo_to(1);
        check_all();
        servo_to(0);
        @(negedge clk_sys_i);
        chk(n_apply, 1);
        // Category 1 stays, history rolls over
        fire(2'h0, 1'b0);
        fire(2'h2, 1'b0);
        clr_param();
        check_all();
        for (int i = 0; i < 4; i++) begin
            fire(2'h0, 1'b0);
            fire(2'h3, 1'b0);
        end
        check_all();
        end_of_test();
    end
endmodule : sfg_top_tb
